// File: rtl/adcssr_pkg.sv
// shared constants and types for the converter command and rate block
package adcssr_pkg;
    localparam logic [7:0] CMD_SYNC = 8'hFC;
    localparam logic [7:0] CMD_SLEEP = 8'hFD;
    localparam logic [7:0] CMD_WAKE = 8'hFB;
    localparam logic [7:0] CMD_RESET = 8'hFE;
    localparam logic [7:0] CMD_CONT = 8'h03;
    localparam logic [7:0] CMD_STOPC = 8'h0F;
    localparam int MOD_BASE = 128;
    localparam int DATA_DECIM = 1280;
    localparam int RES_W = 24;
    localparam logic [1:0] RATE_SEL_MAX = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [8:0] MOD_BASE_W = 9'h080;

    typedef struct packed {
        logic speed;
        logic [1:0] rate_sel;
        logic [2:0] gain_code;
    } adcssr_cfg_t;

    localparam adcssr_cfg_t CFG_RST = '{speed: 1'b0, rate_sel: 2'h0, gain_code: 3'h0};

    typedef enum logic {
        ST_RUN = 1'b0,
        ST_SLEEP = 1'b1
    } adcssr_mode_t;
endpackage : adcssr_pkg

// File: rtl/adcssr_ctrl.sv
// command decoder, sleep and reset control, conversion rate timing
`timescale 1ns/1ps
module adcssr_ctrl
    import adcssr_pkg::*;
#(
    parameter int CONV_BASE = MOD_BASE * DATA_DECIM
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic cfg_load,
    input wire adcssr_cfg_t cfg_in,
    input wire logic signed [RES_W-1:0] analog_in,
    input wire logic link_sclk,
    input wire logic link_cs_n,
    input wire logic link_din,
    output logic link_dout,
    output logic result_ready_n,
    output logic signed [RES_W-1:0] result_data,
    output adcssr_cfg_t cfg_active,
    output logic low_power,
    output logic cont_read_active,
    output logic modulator_tick,
    output logic sample_tick
);
    localparam int CW = 24;

    // modulator divide factor
    function automatic logic [8:0] mfactor(input logic speed);
        mfactor = speed ? {MOD_BASE_W[7:0], 1'b0} : MOD_BASE_W;
    endfunction : mfactor

    // sampling speed-up as a shift from the gain code
    function automatic logic [1:0] samp_shift(input logic [2:0] g);
        case (g)
            3'h4: samp_shift = 2'h1;
            3'h5: samp_shift = 2'h2;
            3'h6, 3'h7: samp_shift = 2'h3;
            default: samp_shift = 2'h0;
        endcase
    endfunction : samp_shift

    // toggle synchroniser output as a one-cycle event
    function automatic logic tog_event(input logic a, input logic b);
        tog_event = a ^ b;
    endfunction : tog_event

    // data-rate field limited to its top legal value
    function automatic logic [1:0] clamp_rate(input logic [1:0] r);
        clamp_rate = (r > RATE_SEL_MAX) ? RATE_SEL_MAX : r;
    endfunction : clamp_rate

    // link domain: byte receive and result shift-out
    logic [7:0] in_sh_r, in_sh_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] byte_hold_r, byte_hold_nxt;
    logic cmd_tog_r, cmd_tog_nxt;
    logic [RES_W-1:0] out_sh_r, out_sh_nxt;
    logic push_s1_r, push_s2_r, push_s3_r;
    logic frame_clr;

    // clk domain state
    logic cmd_s1_r, cmd_s2_r, cmd_s3_r;
    logic signed [RES_W-1:0] ain_s1_r, ain_s2_r;
    adcssr_cfg_t cfg_r, cfg_nxt;
    adcssr_mode_t mode_r, mode_nxt;
    logic cont_r, cont_nxt;
    logic [8:0] mod_cnt_r, mod_cnt_nxt;
    logic [8:0] samp_cnt_r, samp_cnt_nxt;
    logic [CW-1:0] conv_cnt_r, conv_cnt_nxt;
    logic signed [RES_W-1:0] result_r, result_nxt;
    logic ready_n_r, ready_n_nxt;
    logic push_tog_r, push_tog_nxt;
    logic mod_tick_r, mod_tick_nxt;
    logic samp_tick_r, samp_tick_nxt;

    always_comb begin
        in_sh_nxt = in_sh_r;
        byte_hold_nxt = byte_hold_r;
        cmd_tog_nxt = cmd_tog_r;
        out_sh_nxt = out_sh_r;
        if (!link_cs_n) begin
            in_sh_nxt = {in_sh_r[6:0], link_din};
            if (bit_cnt_r == BIT_LAST) begin
                byte_hold_nxt = {in_sh_r[6:0], link_din};
                cmd_tog_nxt = ~cmd_tog_r;
            end
            out_sh_nxt = {out_sh_r[RES_W-2:0], 1'b0};
        end
        if (tog_event(push_s2_r, push_s3_r)) begin
            out_sh_nxt = result_r;
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_sh_r <= 8'h00;
            byte_hold_r <= 8'h00;
            cmd_tog_r <= 1'b0;
            out_sh_r <= 24'h000000;
            link_dout <= 1'b0;
        end else begin
            in_sh_r <= in_sh_nxt;
            byte_hold_r <= byte_hold_nxt;
            cmd_tog_r <= cmd_tog_nxt;
            out_sh_r <= out_sh_nxt;
            link_dout <= out_sh_nxt[RES_W-1];
        end
    end

    // result push toggle into the link domain
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            push_s1_r <= 1'b0;
            push_s2_r <= 1'b0;
            push_s3_r <= 1'b0;
        end else begin
            push_s1_r <= push_tog_r;
            push_s2_r <= push_s1_r;
            push_s3_r <= push_s2_r;
        end
    end

    // frame bit counter, cleared at once when the frame is deselected
    assign frame_clr = sys_rst | link_cs_n;
    always_comb begin
        bit_cnt_nxt = bit_cnt_r + 3'h1;
    end

    always_ff @(posedge link_sclk or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_r <= 3'h0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    // clk domain next state
    logic cmd_ev;
    logic restart;
    logic [8:0] mf;
    logic [8:0] sdiv;
    logic [CW-1:0] period;
    // command and configuration group
    always_comb begin
        cmd_ev = tog_event(cmd_s2_r, cmd_s3_r);
        restart = 1'b0;
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        cont_nxt = cont_r;
        if (cfg_load) begin
            cfg_nxt = cfg_in;
            cfg_nxt.rate_sel = clamp_rate(cfg_in.rate_sel);
        end
        if (cmd_ev) begin
            unique case (byte_hold_r)
                CMD_SYNC: restart = 1'b1;
                CMD_SLEEP: mode_nxt = ST_SLEEP;
                CMD_WAKE: begin
                    mode_nxt = ST_RUN;
                    restart = 1'b1;
                end
                CMD_RESET: begin
                    cfg_nxt = CFG_RST;
                    cont_nxt = 1'b0;
                    restart = 1'b1;
                end
                CMD_CONT: cont_nxt = 1'b1;
                CMD_STOPC: cont_nxt = 1'b0;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r <= CFG_RST;
            mode_r <= ST_RUN;
            cont_r <= 1'b0;
        end else if (ce) begin
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            cont_r <= cont_nxt;
        end
    end

    // command toggle and input sample synchronisers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_s1_r <= 1'b0;
            cmd_s2_r <= 1'b0;
            cmd_s3_r <= 1'b0;
            ain_s1_r <= 24'sh000000;
            ain_s2_r <= 24'sh000000;
        end else if (ce) begin
            cmd_s1_r <= cmd_tog_r;
            cmd_s2_r <= cmd_s1_r;
            cmd_s3_r <= cmd_s2_r;
            ain_s1_r <= analog_in;
            ain_s2_r <= ain_s1_r;
        end
    end

    // conversion timing group
    always_comb begin
        mod_cnt_nxt = mod_cnt_r;
        samp_cnt_nxt = samp_cnt_r;
        conv_cnt_nxt = conv_cnt_r;
        result_nxt = result_r;
        ready_n_nxt = ready_n_r;
        push_tog_nxt = push_tog_r;
        mod_tick_nxt = 1'b0;
        samp_tick_nxt = 1'b0;
        mf = mfactor(cfg_r.speed);
        sdiv = mf >> samp_shift(cfg_r.gain_code);
        period = CW'(CONV_BASE) << (cfg_r.speed + cfg_r.rate_sel);
        if (restart || mode_r == ST_SLEEP) begin
            mod_cnt_nxt = 9'h000;
            samp_cnt_nxt = 9'h000;
            conv_cnt_nxt = '0;
            ready_n_nxt = 1'b1;
        end else begin
            if (mod_cnt_r >= mf - 9'h001) begin
                mod_cnt_nxt = 9'h000;
                mod_tick_nxt = 1'b1;
            end else begin
                mod_cnt_nxt = mod_cnt_r + 9'h001;
            end
            if (samp_cnt_r >= sdiv - 9'h001) begin
                samp_cnt_nxt = 9'h000;
                samp_tick_nxt = 1'b1;
            end else begin
                samp_cnt_nxt = samp_cnt_r + 9'h001;
            end
            if (conv_cnt_r >= period - CW'(1)) begin
                conv_cnt_nxt = '0;
                result_nxt = ain_s2_r;
                ready_n_nxt = 1'b0;
                if (cont_r) begin
                    push_tog_nxt = ~push_tog_r;
                end
            end else begin
                conv_cnt_nxt = conv_cnt_r + CW'(1);
                if (conv_cnt_r == (period >> 1)) begin
                    ready_n_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mod_cnt_r <= 9'h000;
            samp_cnt_r <= 9'h000;
            conv_cnt_r <= '0;
            result_r <= 24'sh000000;
            ready_n_r <= 1'b1;
            push_tog_r <= 1'b0;
            mod_tick_r <= 1'b0;
            samp_tick_r <= 1'b0;
        end else if (ce) begin
            mod_cnt_r <= mod_cnt_nxt;
            samp_cnt_r <= samp_cnt_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            result_r <= result_nxt;
            ready_n_r <= ready_n_nxt;
            push_tog_r <= push_tog_nxt;
            mod_tick_r <= mod_tick_nxt;
            samp_tick_r <= samp_tick_nxt;
        end
    end

    // outputs straight from flops
    assign result_ready_n = ready_n_r;
    assign result_data = result_r;
    assign cfg_active = cfg_r;
    assign low_power = (mode_r == ST_SLEEP);
    assign cont_read_active = cont_r;
    assign modulator_tick = mod_tick_r;
    assign sample_tick = samp_tick_r;
endmodule : adcssr_ctrl

// File: sim/adcssr_checker.sv
// assertion checker for the converter command and rate block
`timescale 1ns/1ps
module adcssr_checker
    import adcssr_pkg::*;
#(
    parameter int CONV_BASE = MOD_BASE * DATA_DECIM
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_cs_n,
    input wire logic signed [RES_W-1:0] analog_in,
    input wire logic result_ready_n,
    input wire logic signed [RES_W-1:0] result_data,
    input wire adcssr_cfg_t cfg_active,
    input wire logic low_power,
    input wire logic cont_read_active,
    input wire logic modulator_tick,
    input wire logic sample_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rdy_r;
    logic clr;
    adcssr_cfg_t cfg_r;
    logic [2:0] ev;
    logic [2:0] vld_r;
    int cnt_r [3];
    int per [3];
    int sh;
    always_comb begin
        sh = (cfg_active.gain_code < 3'h4) ? 0 : (cfg_active.gain_code == 3'h7) ? 3 :
            int'(cfg_active.gain_code) - 3;
        per[0] = MOD_BASE << cfg_active.speed;
        per[1] = per[0] >> sh;
        per[2] = CONV_BASE << (int'(cfg_active.speed) + int'(cfg_active.rate_sel));
        ev = {~result_ready_n & rdy_r, sample_tick, modulator_tick};
        clr = low_power || !link_cs_n || cfg_active != cfg_r;
    end
    // interval since last event, void after commands or config change
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_r <= 1'b1;
            cfg_r <= CFG_RST;
            vld_r <= 3'h0;
            cnt_r <= '{0, 0, 0};
        end else begin
            rdy_r <= result_ready_n;
            cfg_r <= cfg_active;
            for (int i = 0; i < 3; i++) begin
                vld_r[i] <= !clr && (ev[i] || vld_r[i]);
                cnt_r[i] <= ev[i] ? 0 : cnt_r[i] + 1;
            end
        end
    end
    AST_SLEEP_QUIET: assert property (
        low_power && $past(low_power) |-> !modulator_tick && !sample_tick && result_ready_n)
        else $error("activity while asleep");
    AST_MODE_BY_CMD: assert property (
        $changed(low_power) |-> !link_cs_n) else $error("sleep state moved without a command");
    AST_CONT_BY_CMD: assert property (
        $changed(cont_read_active) |-> !link_cs_n) else $error("continuous mode moved alone");
    AST_MOD_PERIOD: assert property (
        modulator_tick && vld_r[0] |-> cnt_r[0] == per[0] - 1) else $error("modulator period");
    AST_SAMP_PERIOD: assert property (
        sample_tick && vld_r[1] |-> cnt_r[1] == per[1] - 1) else $error("sample period");
    AST_RESULT_GAP: assert property (
        ev[2] && vld_r[2] |-> cnt_r[2] == per[2] - 1) else $error("result period");
    AST_RESULT_HOLD: assert property (
        $changed(result_data) |-> $fell(result_ready_n)) else $error("result moved off ready");
    AST_RESULT_VALUE: assert property (
        $fell(result_ready_n) && analog_in == $past(analog_in, 4) |-> result_data == analog_in)
        else $error("result differs from input");
    cover property ($rose(low_power));
    cover property ($fell(cont_read_active));
    cover property (ev[2] && vld_r[2]);
endmodule : adcssr_checker

// File: sim/adcssr_host.sv
// host model that shifts command bytes over the serial link
`timescale 1ns/1ps
module adcssr_host
    import adcssr_pkg::*;
(
    input wire logic link_dout,
    output logic link_sclk,
    output logic link_cs_n,
    output logic link_din
);
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_din = 1'b1;
    end
    // msb first, n bits, clock still between frames
    task automatic send(input logic [7:0] b, input int n);
        link_cs_n = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            link_din = b[i];
            #62.5 link_sclk = 1'b1;
            #62.5 link_sclk = 1'b0;
        end
        link_din = ~link_din;
        link_cs_n = 1'b1;
        #125;
    endtask : send
    // clocks one pushed result out, msb first; the frame's first byte stops the mode
    task automatic read(output logic [RES_W-1:0] v);
        v = '0;
        for (int i = 0; i < 27; i++) begin
            link_cs_n = (i < 4);
            link_din = (i >= 4 && i < 12) ? CMD_STOPC[11 - i] : 1'b0;
            #62.5 link_sclk = 1'b1;
            #62.5 link_sclk = 1'b0;
            if (i >= 3) begin
                v = {v[RES_W-2:0], link_dout};
            end
        end
        link_din = ~link_din;
        link_cs_n = 1'b1;
        #125;
    endtask : read
endmodule : adcssr_host

// File: sim/tb_adc_sync_sleep_reset_rate_ctrl.sv
// testbench for the converter command and rate block
`timescale 1ns/1ps
module tb_adc_sync_sleep_reset_rate_ctrl;
    import adcssr_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cfg_load = 1'b0;
    adcssr_cfg_t cfg_in = CFG_RST;
    logic signed [RES_W-1:0] analog_in = 24'h012345;
    logic link_sclk, link_cs_n, link_din, result_ready_n, low_power, cont_read_active;
    logic modulator_tick, sample_tick, link_dout;
    logic signed [RES_W-1:0] result_data;
    adcssr_cfg_t cfg_active;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    adcssr_host host_u (.link_dout(link_dout), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
        .link_din(link_din));
    adcssr_ctrl #(.CONV_BASE(64)) dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .cfg_load(cfg_load), .cfg_in(cfg_in), .analog_in(analog_in), .link_sclk(link_sclk),
        .link_cs_n(link_cs_n), .link_din(link_din), .link_dout(link_dout),
        .result_ready_n(result_ready_n), .result_data(result_data), .cfg_active(cfg_active),
        .low_power(low_power), .cont_read_active(cont_read_active),
        .modulator_tick(modulator_tick), .sample_tick(sample_tick));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic load(input logic s, input logic [1:0] r, input logic [2:0] g);
        @(posedge clk);
        cfg_in <= '{speed: s, rate_sel: r, gain_code: g};
        cfg_load <= 1'b1;
        analog_in <= -analog_in;
        @(posedge clk);
        cfg_load <= 1'b0;
        #1;
    endtask : load
    task automatic wait_res(output int n);
        logic p;
        p = result_ready_n;
        for (n = 1; n <= 1200; n++) begin
            @(posedge clk);
            #1;
            if (p === 1'b1 && result_ready_n === 1'b0) break;
            p = result_ready_n;
        end
        chk(24'(n <= 1200), 24'h1);
    endtask : wait_res
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        int n;
        logic [23:0] rd;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(24'(cfg_active), 24'(CFG_RST));
        chk(24'({low_power, cont_read_active}), 24'h0);
        for (int g = 0; g < 8; g++) begin
            load(g[0], 2'(g % 3), 3'(g));
            wait_res(n);
            wait_res(n);
            chk(result_data, analog_in);
        end
        load(1'b0, 2'h3, 3'h0);
        chk(24'(cfg_active.rate_sel), 24'(RATE_SEL_MAX));
        $display("test rates done");
        load(1'b1, 2'h2, 3'h6);
        host_u.send(CMD_CONT, 8);
        chk(24'(cont_read_active), 24'h1);
        host_u.send(CMD_RESET, 8);
        chk(24'(cont_read_active), 24'h0);
        chk(24'(cfg_active), 24'(CFG_RST));
        $display("test reset done");
        host_u.send(CMD_SLEEP, 8);
        chk(24'(low_power), 24'h1);
        repeat (600) @(posedge clk);
        #1;
        chk(24'({low_power, result_ready_n}), 24'h3);
        host_u.send(8'hF0, 8);
        host_u.send(CMD_WAKE, 4);
        chk(24'(low_power), 24'h1);
        host_u.send(CMD_WAKE, 8);
        chk(24'(low_power), 24'h0);
        wait_res(n);
        $display("test sleep done");
        load(1'b1, 2'h2, 3'h0);
        host_u.send(CMD_CONT, 8);
        wait_res(n);
        host_u.read(rd);
        chk(rd, analog_in);
        chk(24'(cont_read_active), 24'h0);
        wait_res(n);
        repeat (200) @(posedge clk);
        host_u.send(CMD_SYNC, 8);
        chk(24'(result_ready_n), 24'h1);
        wait_res(n);
        chk(24'(n > 448 && n <= 512), 24'h1);
        $display("test sync done");
        report_and_stop();
    end
endmodule : tb_adc_sync_sleep_reset_rate_ctrl
bind adcssr_ctrl adcssr_checker #(.CONV_BASE(CONV_BASE)) chk_u (.clk(clk), .sys_rst(sys_rst),
    .link_cs_n(link_cs_n), .analog_in(analog_in), .result_ready_n(result_ready_n),
    .result_data(result_data), .cfg_active(cfg_active), .low_power(low_power),
    .cont_read_active(cont_read_active), .modulator_tick(modulator_tick),
    .sample_tick(sample_tick));
